// ---- rtl/ebw_boot_wb.sv ----
`timescale 1ns/100ps
`default_nettype none
module ebw_boot_wb import ebw_pkg::*; (
  input  wire logic                   i_clk,                     // core clock
  input  wire logic                   i_srst,                    // sync reset
  input  wire logic                   i_lnk_clk,                 // 64x fs link clock
  input  wire logic                   i_active_low_reset_pin,    // device reset pin
  input  wire logic                   i_boot_sel_pin,            // self-boot select pin
  input  wire logic                   i_wp_i,                    // write-protect line level
  input  wire logic                   i_writeback_trigger_pin,   // writeback trigger
  input  wire logic                   i_sda_i,                   // sda line level
  input  wire ebw_ifw_s               i_dsp_ifw,                 // dsp program write
  input  wire ebw_ifw_s               i_port_ifw,                // control port write
  input  wire logic                   i_core_ctl_we,             // core control write
  input  wire logic [15:0]            i_core_ctl_data,           // core control data
  output logic                        o_scl,                     // serial clock
  output logic                        o_sda_o,                   // sda drive level
  output logic                        o_sda_oe,                  // sda pulled low
  output logic                        o_wp_o,                    // wp drive level
  output logic                        o_wp_oe,                   // wp pulled low
  output logic                        o_port_en,                 // port writes enabled
  output ebw_bwr_s                    o_boot_wr,                 // boot write byte
  output logic                        o_boot_busy,               // reading eeprom
  output logic                        o_wb_busy,                 // writeback running
  output logic                        o_nack_err,                // eeprom refused a byte
  output logic [IFR_NUM-1:0][31:0]    o_ifr                      // interface registers
);

  typedef enum logic [3:0] {
    ST_OFF, ST_HDR, ST_TYPE, ST_LEN, ST_WHDR, ST_WDATA, ST_DLYV, ST_DELAY,
    ST_FIN, ST_WAIT, ST_DONE, ST_WB
  } ebw_st_e;

  logic rstn_s1_reg, rstn_s2_reg, sel_s1_reg, sel_s2_reg, wp_s1_reg, wp_s2_reg;
  logic trg_s1_reg, trg_s2_reg, ack_s1_reg, ack_s2_reg;
  logic rstn_prev_reg, trg_prev_reg;
  logic eng_ack, eng_scl, eng_oe;
  ebw_rsp_s eng_rsp;

  ebw_st_e st_reg, st_next;
  logic [15:0] idx_reg, idx_next, len_reg, len_next, sub_reg, sub_next, dly_reg, dly_next;
  logic [7:0] unit_reg, unit_next;
  logic chip_ok_reg, chip_ok_next, multi_reg, multi_next, fall_reg, fall_next;
  logic wb_done_reg, wb_done_next, fin_wait_reg, fin_wait_next;
  logic req_reg, req_next, pend_reg, pend_next, wp_oe_reg, wp_oe_next;
  logic err_reg, err_next;
  logic boot_busy_reg, boot_busy_next, wb_busy_reg, wb_busy_next;
  ebw_cmd_s cmd_reg, cmd_next;
  ebw_bwr_s bwr_reg, bwr_next;
  logic [IFR_NUM-1:0][31:0] ifr_reg, snap_reg, snap_next;
  logic port_en_reg, port_en_next;
  logic done, idle, trig;
  logic [7:0] rxb;

  ebw_i2c_eng u_eng (
    .i_lnk_clk (i_lnk_clk),
    .i_srst    (i_srst),
    .i_req_tgl (req_reg),
    .i_cmd     (cmd_reg),
    .i_sda_i   (i_sda_i),
    .o_ack_tgl (eng_ack),
    .o_rsp     (eng_rsp),
    .o_scl     (o_scl),
    .o_sda_oe  (o_sda_oe)
  );

  always_ff @(posedge i_clk) begin
    rstn_s1_reg <= i_active_low_reset_pin;
    rstn_s2_reg <= rstn_s1_reg;
    sel_s1_reg  <= i_boot_sel_pin;
    sel_s2_reg  <= sel_s1_reg;
    wp_s1_reg   <= i_wp_i;
    wp_s2_reg   <= wp_s1_reg;
    trg_s1_reg  <= i_writeback_trigger_pin;
    trg_s2_reg  <= trg_s1_reg;
    ack_s1_reg  <= eng_ack;
    ack_s2_reg  <= ack_s1_reg;
  end

  function automatic ebw_cmd_s mk_cmd(input logic st, input logic sp, input logic rd,
                                      input logic ma, input logic [7:0] d);
    mk_cmd = '{start: st, stop: sp, rd: rd, mack: ma, data: d};
  endfunction

  // byte k of the writeback transaction
  function automatic ebw_cmd_s wb_cmd(input logic [15:0] k,
                                      input logic [IFR_NUM-1:0][31:0] snap);
    logic [15:0] d;
    logic [1:0]  lane;
    d    = k - WB_HDR_BYTES;
    lane = 2'h3 - d[1:0];
    if (k == 16'h0000) begin
      wb_cmd = mk_cmd(1'b1, 1'b0, 1'b0, 1'b0, EE_DEV_WR);
    end else if (k == 16'h0001) begin
      wb_cmd = mk_cmd(1'b0, 1'b0, 1'b0, 1'b0, EE_WB_ADR_H);
    end else if (k == 16'h0002) begin
      wb_cmd = mk_cmd(1'b0, 1'b0, 1'b0, 1'b0, EE_WB_ADR_L);
    end else begin
      // msb-first bytes of the snapped registers, stop on the last byte
      wb_cmd = mk_cmd(1'b0, k == WB_TOTAL - 16'h0001, 1'b0, 1'b0,
                      snap[d[4:2]][{lane, 3'h0} +: 8]);
    end
  endfunction

  always_comb begin
    done = pend_reg && (ack_s2_reg == req_reg);
    idle = !pend_reg || done;
    rxb  = eng_rsp.data;
    trig = fall_reg ? (~trg_s2_reg & trg_prev_reg) : (trg_s2_reg & ~trg_prev_reg);
    st_next       = st_reg;
    idx_next      = idx_reg;
    len_next      = len_reg;
    sub_next      = sub_reg;
    dly_next      = dly_reg;
    unit_next     = unit_reg;
    chip_ok_next  = chip_ok_reg;
    multi_next    = multi_reg;
    fall_next     = fall_reg;
    wb_done_next  = wb_done_reg;
    fin_wait_next = fin_wait_reg;
    req_next      = req_reg;
    pend_next     = pend_reg & ~done;
    cmd_next      = cmd_reg;
    wp_oe_next    = wp_oe_reg;
    snap_next     = snap_reg;
    bwr_next      = '0;
    err_next      = err_reg | (done & ~cmd_reg.rd & eng_rsp.nack);
    unique case (st_reg)
      ST_OFF: begin
        if (rstn_s2_reg && !rstn_prev_reg && sel_s2_reg && wp_s2_reg) begin
          st_next      = ST_HDR;
          idx_next     = 16'h0000;
          multi_next   = 1'b0;
          fall_next    = 1'b0;
          wb_done_next = 1'b0;
        end
      end
      ST_HDR: begin
        if (idle) begin
          if (idx_reg == BOOT_HDR_CMDS) begin
            st_next = ST_TYPE;
          end else begin
            req_next  = ~req_reg;
            pend_next = 1'b1;
            idx_next  = idx_reg + 16'h0001;
            unique case (idx_reg[1:0])
              2'h0: cmd_next = mk_cmd(1'b1, 1'b0, 1'b0, 1'b0, EE_DEV_WR);
              2'h1: cmd_next = mk_cmd(1'b0, 1'b0, 1'b0, 1'b0, EE_BOOT_ADR_H);
              2'h2: cmd_next = mk_cmd(1'b0, 1'b0, 1'b0, 1'b0, EE_BOOT_ADR_L);
              2'h3: cmd_next = mk_cmd(1'b1, 1'b0, 1'b0, 1'b0, EE_DEV_RD);
            endcase
          end
        end
      end
      ST_TYPE, ST_LEN, ST_WHDR, ST_WDATA, ST_DLYV: begin
        if (!pend_reg) begin
          req_next  = ~req_reg;
          pend_next = 1'b1;
          cmd_next  = mk_cmd(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
        end else if (done) begin
          idx_next = idx_reg + 16'h0001;
          unique case (st_reg)
            ST_TYPE: begin
              idx_next = 16'h0000;
              unique case (rxb)
                MSG_WRITE:    st_next = ST_LEN;
                MSG_DELAY:    st_next = ST_DLYV;
                MSG_NOP:      st_next = ST_TYPE;
                MSG_MULTI_WB: multi_next = 1'b1;
                MSG_WB_FALL:  fall_next = 1'b1;
                MSG_END_WAIT: begin
                  fin_wait_next = 1'b1;
                  st_next       = ST_FIN;
                end
                default: begin
                  fin_wait_next = 1'b0;
                  st_next       = ST_FIN;
                end
              endcase
            end
            ST_LEN: begin
              len_next = {len_reg[7:0], rxb};
              if (idx_reg[0]) begin
                st_next  = ST_WHDR;
                idx_next = 16'h0000;
              end
            end
            ST_WHDR: begin
              if (idx_reg == 16'h0000) begin
                chip_ok_next = rxb == MSG_CHIP_ADR;
              end else begin
                sub_next = {sub_reg[7:0], rxb};
              end
              if (idx_reg == 16'h0002) begin
                idx_next = 16'h0000;
                len_next = len_reg - WR_HDR_BYTES;
                st_next  = (len_reg > WR_HDR_BYTES) ? ST_WDATA : ST_TYPE;
              end
            end
            ST_WDATA: begin
              bwr_next = '{valid: chip_ok_reg, sub: sub_reg, off: idx_reg, data: rxb};
              len_next = len_reg - 16'h0001;
              if (len_reg == 16'h0001) begin
                st_next = ST_TYPE;
              end
            end
            default: begin
              dly_next = {dly_reg[7:0], rxb};
              if (idx_reg[0]) begin
                st_next   = ST_DELAY;
                unit_next = 8'h00;
              end
            end
          endcase
        end
      end
      ST_DELAY: begin
        if (dly_reg == 16'h0000) begin
          st_next = ST_TYPE;
        end else if (unit_reg == DLY_UNIT_CYC - 8'h01) begin
          unit_next = 8'h00;
          dly_next  = dly_reg - 16'h0001;
        end else begin
          unit_next = unit_reg + 8'h01;
        end
      end
      ST_FIN: begin
        // one extra byte read without ack lets the eeprom release sda for the stop
        if (!pend_reg) begin
          req_next  = ~req_reg;
          pend_next = 1'b1;
          cmd_next  = mk_cmd(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
        end else if (done) begin
          st_next = fin_wait_reg ? ST_WAIT : ST_DONE;
        end
      end
      ST_WAIT: begin
        if (trig && (multi_reg || !wb_done_reg)) begin
          st_next      = ST_WB;
          idx_next     = 16'h0000;
          wb_done_next = 1'b1;
          wp_oe_next   = 1'b1;
          snap_next    = ifr_reg;
        end
      end
      ST_WB: begin
        if (idle) begin
          if (idx_reg == WB_TOTAL) begin
            st_next    = ST_WAIT;
            wp_oe_next = 1'b0;
          end else begin
            req_next  = ~req_reg;
            pend_next = 1'b1;
            cmd_next  = wb_cmd(idx_reg, snap_reg);
            idx_next  = idx_reg + 16'h0001;
          end
        end
      end
      ST_DONE: begin
      end
    endcase
    if (!rstn_s2_reg) begin
      st_next    = ST_OFF;
      wp_oe_next = 1'b0;
    end
    wb_busy_next   = st_next == ST_WB;
    boot_busy_next = !(st_next inside {ST_OFF, ST_WAIT, ST_DONE, ST_WB});
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg        <= ST_OFF;
      idx_reg       <= 16'h0000;
      len_reg       <= 16'h0000;
      sub_reg       <= 16'h0000;
      dly_reg       <= 16'h0000;
      unit_reg      <= 8'h00;
      chip_ok_reg   <= 1'b0;
      multi_reg     <= 1'b0;
      fall_reg      <= 1'b0;
      wb_done_reg   <= 1'b0;
      fin_wait_reg  <= 1'b0;
      req_reg       <= 1'b0;
      pend_reg      <= 1'b0;
      cmd_reg       <= '0;
      wp_oe_reg     <= 1'b0;
      snap_reg      <= '0;
      bwr_reg       <= '0;
      err_reg       <= 1'b0;
      rstn_prev_reg <= 1'b0;
      trg_prev_reg  <= 1'b0;
      boot_busy_reg <= 1'b0;
      wb_busy_reg   <= 1'b0;
    end else begin
      st_reg        <= st_next;
      idx_reg       <= idx_next;
      len_reg       <= len_next;
      sub_reg       <= sub_next;
      dly_reg       <= dly_next;
      unit_reg      <= unit_next;
      chip_ok_reg   <= chip_ok_next;
      multi_reg     <= multi_next;
      fall_reg      <= fall_next;
      wb_done_reg   <= wb_done_next;
      fin_wait_reg  <= fin_wait_next;
      req_reg       <= req_next;
      pend_reg      <= pend_next;
      cmd_reg       <= cmd_next;
      wp_oe_reg     <= wp_oe_next;
      snap_reg      <= snap_next;
      bwr_reg       <= bwr_next;
      err_reg       <= err_next;
      rstn_prev_reg <= rstn_s2_reg;
      trg_prev_reg  <= trg_s2_reg;
      boot_busy_reg <= boot_busy_next;
      wb_busy_reg   <= wb_busy_next;
    end
  end

  // port-enable bit of the core control register, low byte of a boot write
  always_comb begin
    port_en_next = port_en_reg;
    if (i_core_ctl_we) begin
      port_en_next = i_core_ctl_data[PORT_EN_BIT];
    end
    if (bwr_next.valid && bwr_next.sub == CORE_CTL_SUB && bwr_next.off == CORE_CTL_LO) begin
      port_en_next = bwr_next.data[PORT_EN_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      port_en_reg <= 1'b0;
    end else begin
      port_en_reg <= port_en_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < IFR_NUM; gi++) begin : g_ifr
      logic [31:0] val_next;
      logic [15:0] bidx;
      logic [1:0]  lane;
      always_comb begin
        bidx     = bwr_next.sub - IFR_SUB_BASE + {2'h0, bwr_next.off[15:2]};
        lane     = 2'h3 - bwr_next.off[1:0];
        val_next = ifr_reg[gi];
        if (i_dsp_ifw.we && i_dsp_ifw.idx == 3'(gi)) begin
          val_next = i_dsp_ifw.data;
        end
        if (port_en_reg && i_port_ifw.we && i_port_ifw.idx == 3'(gi)) begin
          val_next = i_port_ifw.data;
        end
        if (port_en_reg && bwr_next.valid && bwr_next.sub >= IFR_SUB_BASE
            && bidx < IFR_NUM_W && bidx[2:0] == 3'(gi)) begin
          val_next[{lane, 3'h0} +: 8] = bwr_next.data;
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          ifr_reg[gi] <= 32'h0000_0000;
        end else begin
          ifr_reg[gi] <= val_next;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    o_sda_o <= 1'b0;
    o_wp_o  <= 1'b0;
  end

  assign o_wp_oe     = wp_oe_reg;
  assign o_port_en   = port_en_reg;
  assign o_boot_wr   = bwr_reg;
  assign o_nack_err  = err_reg;
  assign o_ifr       = ifr_reg;
  assign o_boot_busy = boot_busy_reg;
  assign o_wb_busy   = wb_busy_reg;

endmodule
`default_nettype wire

// ---- rtl/ebw_i2c_eng.sv ----
`timescale 1ns/100ps
`default_nettype none
module ebw_i2c_eng import ebw_pkg::*; (
  input  wire logic     i_lnk_clk,  // link clock, 64x sample rate
  input  wire logic     i_srst,     // reset from core domain
  input  wire logic     i_req_tgl,  // command toggle from core domain
  input  wire ebw_cmd_s i_cmd,      // command, stable while pending
  input  wire logic     i_sda_i,    // sda pin level
  output logic          o_ack_tgl,  // completion toggle
  output ebw_rsp_s      o_rsp,      // read byte and ack bit
  output logic          o_scl,      // serial clock
  output logic          o_sda_oe    // pull sda low
);

  typedef enum logic [1:0] {ENG_IDLE, ENG_START, ENG_BITS, ENG_STOP} ebw_eng_e;

  logic rst_s1_reg, rst_s2_reg, req_s1_reg, req_s2_reg, sda_s1_reg, sda_s2_reg;
  ebw_eng_e st_reg, st_next;
  logic [2:0] ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  ebw_cmd_s cmd_reg, cmd_next;
  ebw_rsp_s rsp_reg, rsp_next;
  logic held_reg, held_next, seen_reg, seen_next, ack_reg, ack_next;
  logic scl_reg, scl_next, oe_reg, oe_next;

  always_ff @(posedge i_lnk_clk) begin
    rst_s1_reg <= i_srst;
    rst_s2_reg <= rst_s1_reg;
    req_s1_reg <= i_req_tgl;
    req_s2_reg <= req_s1_reg;
    sda_s1_reg <= i_sda_i;
    sda_s2_reg <= sda_s1_reg;
  end

  always_comb begin
    st_next   = st_reg;
    ph_next   = ph_reg + 3'h1;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    cmd_next  = cmd_reg;
    rsp_next  = rsp_reg;
    held_next = held_reg;
    seen_next = seen_reg;
    ack_next  = ack_reg;
    scl_next  = 1'b1;
    oe_next   = 1'b0;
    unique case (st_reg)
      ENG_IDLE: begin
        ph_next  = 3'h0;
        scl_next = ~held_reg;
        if (req_s2_reg != seen_reg) begin
          seen_next = req_s2_reg;
          cmd_next  = i_cmd;
          sh_next   = i_cmd.rd ? 8'hff : i_cmd.data;
          bit_next  = 4'h0;
          st_next   = i_cmd.start ? ENG_START : ENG_BITS;
        end
      end
      ENG_START: begin
        // sda falls while scl is high: start or repeated start
        scl_next = ~held_reg | (ph_reg >= COND_SCL_PH);
        oe_next  = ph_reg >= START_SDA_PH;
        if (ph_reg == PH_LAST) begin
          st_next = ENG_BITS;
        end
      end
      ENG_BITS: begin
        scl_next = (ph_reg >= SCL_RISE_PH) && (ph_reg < SCL_FALL_PH);
        oe_next  = (bit_reg == ACK_BIT) ? (cmd_reg.rd & cmd_reg.mack)
                                        : (~cmd_reg.rd & ~sh_reg[7]);
        if (ph_reg == PH_LAST) begin
          if (bit_reg == ACK_BIT) begin
            rsp_next = '{data: sh_reg, nack: sda_s2_reg};
            if (cmd_reg.stop) begin
              st_next = ENG_STOP;
            end else begin
              st_next   = ENG_IDLE;
              held_next = 1'b1;
              ack_next  = ~ack_reg;
            end
          end else begin
            sh_next  = {sh_reg[6:0], sda_s2_reg};
            bit_next = bit_reg + 4'h1;
          end
        end
      end
      ENG_STOP: begin
        // sda rises while scl is high
        scl_next = ph_reg >= COND_SCL_PH;
        oe_next  = ph_reg < STOP_SDA_PH;
        if (ph_reg == PH_LAST) begin
          st_next   = ENG_IDLE;
          held_next = 1'b0;
          ack_next  = ~ack_reg;
        end
      end
    endcase
  end

  always_ff @(posedge i_lnk_clk) begin
    if (rst_s2_reg) begin
      st_reg   <= ENG_IDLE;
      ph_reg   <= 3'h0;
      bit_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      cmd_reg  <= '0;
      rsp_reg  <= '0;
      held_reg <= 1'b0;
      seen_reg <= 1'b0;
      ack_reg  <= 1'b0;
      scl_reg  <= 1'b1;
      oe_reg   <= 1'b0;
    end else begin
      st_reg   <= st_next;
      ph_reg   <= ph_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      cmd_reg  <= cmd_next;
      rsp_reg  <= rsp_next;
      held_reg <= held_next;
      seen_reg <= seen_next;
      ack_reg  <= ack_next;
      scl_reg  <= scl_next;
      oe_reg   <= oe_next;
    end
  end

  assign o_ack_tgl = ack_reg;
  assign o_rsp     = rsp_reg;
  assign o_scl     = scl_reg;
  assign o_sda_oe  = oe_reg;

endmodule
`default_nettype wire

// ---- rtl/ebw_pkg.sv ----
package ebw_pkg;

  // boot message types
  localparam logic [7:0] MSG_END      = 8'h00;
  localparam logic [7:0] MSG_WRITE    = 8'h01;
  localparam logic [7:0] MSG_DELAY    = 8'h02;
  localparam logic [7:0] MSG_NOP      = 8'h03;
  localparam logic [7:0] MSG_MULTI_WB = 8'h04;
  localparam logic [7:0] MSG_WB_FALL  = 8'h05;
  localparam logic [7:0] MSG_END_WAIT = 8'h06;
  localparam logic [7:0] MSG_CHIP_ADR = 8'h00;

  // eeprom addressing (8-bit address bytes, r/w bit included)
  localparam logic [7:0] EE_DEV_WR     = 8'h60;
  localparam logic [7:0] EE_DEV_RD     = 8'h61;
  localparam logic [7:0] EE_BOOT_ADR_H = 8'h00;
  localparam logic [7:0] EE_BOOT_ADR_L = 8'h00;
  localparam logic [7:0] EE_WB_ADR_H   = 8'h00;
  localparam logic [7:0] EE_WB_ADR_L   = 8'h20;

  // control space
  localparam logic [15:0] IFR_SUB_BASE  = 16'h0800;
  localparam logic [15:0] CORE_CTL_SUB  = 16'h081c;
  localparam logic [15:0] CORE_CTL_LO   = 16'h0001;
  localparam int          PORT_EN_BIT   = 6;
  localparam int          IFR_NUM       = 8;
  localparam logic [15:0] IFR_NUM_W     = 16'h0008;
  localparam logic [15:0] WR_HDR_BYTES  = 16'h0003;

  // sequencing counts
  localparam logic [15:0] BOOT_HDR_CMDS = 16'h0004;
  localparam logic [15:0] WB_HDR_BYTES  = 16'h0003;
  localparam logic [15:0] WB_TOTAL      = 16'h0023;

  // serial bit slot: eight link clocks per scl period, scl high for three
  localparam logic [2:0] PH_LAST       = 3'h7;
  localparam logic [2:0] SCL_RISE_PH   = 3'h4;
  localparam logic [2:0] SCL_FALL_PH   = 3'h7;
  localparam logic [2:0] COND_SCL_PH   = 3'h3;
  localparam logic [2:0] START_SDA_PH  = 3'h5;
  localparam logic [2:0] STOP_SDA_PH   = 3'h6;
  localparam logic [3:0] ACK_BIT       = 4'h8;

  // delay message unit
  localparam int         CLK_PERIOD_NS = 100;
  localparam int         DLY_UNIT_NS   = 10000;
  localparam logic [7:0] DLY_UNIT_CYC  = 8'(DLY_UNIT_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       rd;
    logic       mack;
    logic [7:0] data;
  } ebw_cmd_s;

  typedef struct packed {
    logic [7:0] data;
    logic       nack;
  } ebw_rsp_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] sub;
    logic [15:0] off;
    logic [7:0]  data;
  } ebw_bwr_s;

  typedef struct packed {
    logic        we;
    logic [2:0]  idx;
    logic [31:0] data;
  } ebw_ifw_s;

endpackage

// ---- sim/ebw_boot_wb_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module ebw_boot_wb_checker import ebw_pkg::*; (
  input wire logic i_clk, i_srst, i_lnk_clk, i_core_ctl_we,
  input wire logic [15:0] i_core_ctl_data,
  input wire ebw_ifw_s i_dsp_ifw, i_port_ifw,
  input wire logic o_scl, o_wp_oe, o_port_en, o_boot_busy, o_wb_busy,
  input wire logic [IFR_NUM-1:0][31:0] o_ifr
);
  logic [11:0] n;
  logic [2:0] di;
  logic [31:0] dd;
  logic pb;
  assign di = i_dsp_ifw.idx;
  assign dd = i_dsp_ifw.data;
  assign pb = i_core_ctl_data[PORT_EN_BIT];
  // writeback length in core cycles
  always_ff @(posedge i_clk) n <= (i_srst || !o_wb_busy) ? 12'h0 : n + 12'h1;
  chk_wp_with_wb: assert property (@(posedge i_clk) disable iff (i_srst)
    o_wp_oe == o_wb_busy) else $error("wp not with writeback");
  chk_wb_bound: assert property (@(posedge i_clk) disable iff (i_srst)
    n < 12'h9c4) else $error("writeback too long");
  chk_wb_length: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(o_wb_busy) |-> n > 12'h3e8) else $error("writeback too short");
  chk_port_gate: assert property (@(posedge i_clk) disable iff (i_srst)
    i_port_ifw.we && !o_port_en && !i_dsp_ifw.we && !o_boot_busy |=> $stable(o_ifr))
    else $error("port write not gated");
  chk_dsp_write: assert property (@(posedge i_clk) disable iff (i_srst)
    i_dsp_ifw.we && !i_port_ifw.we && !o_boot_busy |=> o_ifr[$past(di)] == $past(dd))
    else $error("dsp write lost");
  chk_port_bit: assert property (@(posedge i_clk) disable iff (i_srst)
    i_core_ctl_we && !o_boot_busy |=> o_port_en == $past(pb)) else $error("port enable");
  chk_scl_high: assert property (@(posedge i_lnk_clk) disable iff (i_srst)
    $rose(o_scl) |-> o_scl [*3]) else $error("scl high too short");
  chk_scl_low: assert property (@(posedge i_lnk_clk) disable iff (i_srst)
    $fell(o_scl) |-> !o_scl [*4]) else $error("scl low too short");
  cv_wb: cover property (@(posedge i_clk) $rose(o_wb_busy));
  cv_boot: cover property (@(posedge i_clk) $fell(o_boot_busy));
  cv_gate: cover property (@(posedge i_clk) $fell(o_port_en));
endmodule
`default_nettype wire

// ---- sim/ebw_ee_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ebw_ee_model (
  input  wire logic i_scl,   // serial clock
  input  wire logic i_sda,   // resolved data line
  input  wire logic i_wp,    // write-protect level
  output logic      o_sda_oe // pull data low
);
  logic [7:0] mem [256];
  logic [7:0] sr, dev, ptr;
  logic rd, rph, mack;
  int cnt = 0, nb = 0;
  initial o_sda_oe = 0;
  // start condition
  always @(negedge i_sda) if (i_scl) begin
    cnt = 0;
    nb = 0;
    rph = 0;
    o_sda_oe = 0;
  end
  always @(posedge i_scl) begin
    if (cnt < 8) sr = {sr[6:0], i_sda};
    mack = i_sda;
    cnt++;
  end
  always @(negedge i_scl) begin
    o_sda_oe = 0;
    if (cnt == 8 && !rph) begin
      if (nb == 0) {dev, rd} = {sr, sr[0]};
      else if (nb == 2) ptr = sr;
      else if (nb > 2) begin
        // writes land only while write-protect is pulled low
        if (!i_wp) mem[ptr] = sr;
        ptr++;
      end
      nb++;
      o_sda_oe = nb > 1 || sr[7:1] == 7'h30;
    end else if (cnt == 9) begin
      cnt = 0;
      if (rph) begin
        ptr++;
        rph = !mack;
      end else rph = rd;
    end
    if (rph && cnt < 8) o_sda_oe = !mem[ptr][7 - cnt];
  end
endmodule
`default_nettype wire

// ---- sim/test_ebw_boot_wb.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_ebw_boot_wb;
  import ebw_pkg::*;
  logic clk = 0, lnk = 0, srst = 1, rpin = 0, trig = 0, hold = 0, cwe = 0, sel = 1;
  logic [15:0] cdat = '0;
  ebw_ifw_s dsp = '0, prt = '0;
  ebw_bwr_s bw;
  int nbw = 0;
  logic scl, s_oe, w_oe, m_oe, pen, bb, wb, nack;
  logic [IFR_NUM-1:0][31:0] ifr;
  logic [31:0] want [8];
  int miscompares = 0, check_count = 0;
  wire logic sda = !(s_oe || m_oe);
  wire logic wp = !(w_oe || hold);
  always @(posedge clk) if (bw.valid) nbw++;
  initial forever #50 clk = !clk;
  initial begin
    #7;
    forever #24 lnk = !lnk;
  end
  ebw_boot_wb DUT (.i_clk(clk), .i_srst(srst), .i_lnk_clk(lnk),
    .i_active_low_reset_pin(rpin), .i_boot_sel_pin(sel), .i_wp_i(wp),
    .i_writeback_trigger_pin(trig), .i_sda_i(sda), .i_dsp_ifw(dsp), .i_port_ifw(prt),
    .i_core_ctl_we(cwe), .i_core_ctl_data(cdat), .o_scl(scl), .o_sda_o(),
    .o_sda_oe(s_oe), .o_wp_o(), .o_wp_oe(w_oe), .o_port_en(pen), .o_boot_wr(bw),
    .o_boot_busy(bb), .o_wb_busy(wb), .o_nack_err(nack), .o_ifr(ifr));
  ebw_ee_model EE (.i_scl(scl), .i_sda(sda), .i_wp(wp), .o_sda_oe(m_oe));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wt(bit w, logic v, int lim);
    for (int i = 0; i < lim; i++) begin
      if ((w ? wb : bb) === v) return;
      cyc(1);
    end
    chk("timeout", 0, 1);
    summarize();
  endtask
  task automatic put(int a, logic [63:0] v, int n);
    for (int i = 0; i < n; i++) EE.mem[a + i] = v[8 * (n - 1 - i) +: 8];
  endtask
  task automatic t_boot(logic [47:0] tail);
    int n0;
    for (int i = 0; i < 256; i++) EE.mem[i] = 8'h03;
    put(0, 64'h01000500081c0040, 8);
    put(26, 64'h010023000800, 6);
    for (int j = 0; j < 32; j++) begin
      EE.mem[32 + j] = 8'(j * 13 + 5);
      want[j / 4][31 - 8 * (j % 4) -: 8] = 8'(j * 13 + 5);
    end
    put(64, tail, 6);
    n0 = nbw;
    cyc(2);
    rpin = 1;
    wt(0, 1, 50);
    wt(0, 0, 30000);
    chk("boot_wr", nbw - n0, 34);
    chk("port_en", pen, 1);
    for (int k = 0; k < 8; k++) chk("ifr", ifr[k], want[k]);
  endtask
  task automatic t_gate();
    prt = '{1'b1, 3'h2, 32'h1234abcd};
    want[2] = 32'h1234abcd;
    cyc(1);
    prt.we = 0;
    cwe = 1;
    cyc(1);
    cwe = 0;
    prt = '{1'b1, 3'h3, 32'h0bad0bad};
    cyc(1);
    prt.we = 0;
    dsp = '{1'b1, 3'h5, 32'h5a5a0001};
    want[5] = 32'h5a5a0001;
    cyc(1);
    dsp.we = 0;
    cyc(1);
    chk("port_en", pen, 0);
    for (int k = 0; k < 8; k++) chk("ifr", ifr[k], want[k]);
  endtask
  task automatic t_wb(logic lv);
    for (int j = 0; j < 32; j++) EE.mem[32 + j] = 8'hff;
    trig = lv;
    wt(1, 1, 50);
    chk("wp_drive", w_oe, 1);
    wt(1, 0, 5000);
    chk("wp_free", w_oe, 0);
    chk("dev", EE.dev, 8'h60);
    chk("bytes", EE.nb, 35);
    for (int j = 0; j < 32; j++)
      chk("page2", EE.mem[32 + j], want[j / 4][31 - 8 * (j % 4) -: 8]);
  endtask
  task automatic t_edge();
    trig = 1;
    cyc(30);
    chk("rise_ignored", wb, 0);
    t_wb(0);
    dsp = '{1'b1, 3'h0, 32'hfeed0002};
    want[0] = 32'hfeed0002;
    cyc(1);
    dsp.we = 0;
    trig = 1;
    cyc(30);
    t_wb(0);
  endtask
  task automatic t_no_boot();
    for (int i = 0; i < 2; i++) begin
      hold = (i == 0);
      sel = hold;
      rpin = 0;
      cyc(5);
      rpin = 1;
      cyc(40);
      chk("no_boot", bb, 0);
    end
    hold = 0;
    sel = 1;
    rpin = 0;
  endtask
  task automatic t_single();
    t_boot(48'h030303030306);
    t_wb(1);
    trig = 0;
    cyc(30);
    trig = 1;
    cyc(30);
    chk("single_wb", wb, 0);
    chk("nack", nack, 0);
  endtask
  initial begin
    cyc(12);
    srst = 0;
    t_boot(48'h040502000106);
    t_gate();
    t_edge();
    t_no_boot();
    t_single();
    summarize();
  end
endmodule
bind ebw_boot_wb ebw_boot_wb_checker u_chk (.i_clk(i_clk), .i_srst(i_srst),
  .i_lnk_clk(i_lnk_clk), .i_core_ctl_we(i_core_ctl_we), .i_core_ctl_data(i_core_ctl_data),
  .i_dsp_ifw(i_dsp_ifw), .i_port_ifw(i_port_ifw), .o_scl(o_scl), .o_wp_oe(o_wp_oe),
  .o_port_en(o_port_en), .o_boot_busy(o_boot_busy), .o_wb_busy(o_wb_busy), .o_ifr(o_ifr));
`default_nettype wire
